//--- src/tpc_defs.svh
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH

// register offsets on the serial port
`define TPC_OFS_SYNC_HI     6'h04
`define TPC_OFS_SYNC_LO     6'h05
`define TPC_OFS_PKT_LEN     6'h06
`define TPC_OFS_PKT_CTRL    6'h08
`define TPC_OFS_STATION     6'h09
`define TPC_OFS_HOP         6'h0a
`define TPC_OFS_CARRIER_HI  6'h0d
`define TPC_OFS_CARRIER_MID 6'h0e
`define TPC_OFS_CARRIER_LO  6'h0f
`define TPC_OFS_RATE_EXP    6'h10
`define TPC_OFS_RATE_MANT   6'h11

// reset values
`define TPC_RST_SYNC_HI     8'hd3
`define TPC_RST_SYNC_LO     8'h91
`define TPC_RST_PKT_LEN     8'hff
`define TPC_RST_PKT_CTRL    7'h45
`define TPC_RST_STATION     8'h00
`define TPC_RST_HOP         8'h00
`define TPC_RST_CARRIER_HI  6'h1e
`define TPC_RST_CARRIER_MID 8'hc4
`define TPC_RST_CARRIER_LO  8'hec
`define TPC_RST_RATE_EXP    4'hc
`define TPC_RST_RATE_MANT   8'h22
`define TPC_RATE_EXP_RSVD   4'h8

// field positions
`define TPC_CTRL_WHITE_BIT  6
`define TPC_CTRL_FMT_LO     4
`define TPC_CTRL_CRC_BIT    2
`define TPC_CTRL_LEN_LO     0
`define TPC_HDR_READ_BIT    7
`define TPC_HDR_BURST_BIT   6

// symbol-rate accumulator and pattern generator
`define TPC_RATE_ACC_W      28
`define TPC_PN9_SEED        9'h1ff

`endif

//--- src/tpc_pkg.sv
`default_nettype none
package tpc_pkg;
    // serial port framing states, gray along idle-addr-data-hold
    typedef enum logic [1:0] {
        TPC_SPI_IDLE = 2'b00,
        TPC_SPI_ADDR = 2'b01,
        TPC_SPI_DATA = 2'b11,
        TPC_SPI_HOLD = 2'b10
    } tpc_spi_state_type;
    // transmit data source
    typedef enum logic [1:0] {
        TPC_FMT_FIFO  = 2'b00,
        TPC_FMT_SYNC  = 2'b01,
        TPC_FMT_PN9   = 2'b10,
        TPC_FMT_ASYNC = 2'b11
    } tpc_fmt_type;
    // packet length configuration
    typedef enum logic [1:0] {
        TPC_LEN_FIXED    = 2'b00,
        TPC_LEN_VARIABLE = 2'b01,
        TPC_LEN_INFINITE = 2'b10,
        TPC_LEN_RESERVED = 2'b11
    } tpc_len_type;
endpackage
`default_nettype wire

//--- src/tpc_spi_shifter.sv
`default_nettype none
module tpc_spi_shifter (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // serial pins
    input  wire logic       csn,
    input  wire logic       sclk,
    input  wire logic       mosi,
    output var  logic       miso,
    // byte side
    input  wire logic [7:0] tx_byte,
    output var  logic [7:0] rx_byte,
    output var  logic       byte_done
);
    logic       sclk_q_r;
    logic [2:0] cnt_r, cnt_nxt;
    logic [7:0] rx_r, rx_nxt;
    logic [7:0] tx_r, tx_nxt;
    logic       done_r, done_nxt;
    logic       miso_r, miso_nxt;
    logic       rise, fall;

    // edges of the serial clock inside a frame
    assign rise = ~csn & sclk & ~sclk_q_r;
    assign fall = ~csn & ~sclk & sclk_q_r;

    // shift in on rising, out on falling, load after each byte
    always_comb begin
        cnt_nxt  = cnt_r;
        rx_nxt   = rx_r;
        tx_nxt   = tx_r;
        done_nxt = 1'b0;
        miso_nxt = miso_r;
        if (csn) begin
            cnt_nxt  = 3'h0;
            tx_nxt   = 8'h00;
            miso_nxt = 1'b0;
        end else if (done_r) begin
            tx_nxt   = tx_byte;
            miso_nxt = tx_byte[7];
        end else if (rise) begin
            rx_nxt  = {rx_r[6:0], mosi};
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == 3'h7) begin
                done_nxt = 1'b1;
            end
        end else if (fall && cnt_r != 3'h0) begin
            tx_nxt   = {tx_r[6:0], 1'b0};
            miso_nxt = tx_r[6];
        end
    end

    // registers
    always_ff @(posedge clk) begin
        if (rst) begin
            sclk_q_r <= 1'b0;
            cnt_r    <= 3'h0;
            rx_r     <= 8'h00;
            tx_r     <= 8'h00;
            done_r   <= 1'b0;
            miso_r   <= 1'b0;
        end else begin
            sclk_q_r <= sclk;
            cnt_r    <= cnt_nxt;
            rx_r     <= rx_nxt;
            tx_r     <= tx_nxt;
            done_r   <= done_nxt;
            miso_r   <= miso_nxt;
        end
    end

    assign miso      = miso_r;
    assign rx_byte   = rx_r;
    assign byte_done = done_r;
endmodule
`default_nettype wire

//--- src/tpc_config_regs.sv
// Contract
// - sync high byte register, reset d3
// - sync low byte register, reset 91
// - packet length: fixed length or maximum
// - format 00 sends bytes from fifo
// - format 01 synchronous serial from pin
// - format 10 sends pn9 test pattern
// - format 11 transparent asynchronous from pin
// - length mode 00 fixed length
// - length mode 01 variable, first byte
// - length mode 10 infinite, 11 reserved
// - station address register, reset zero
// - frequency is base plus channel times spacing
// - carrier word top two bits read zero
// - carrier word is synthesizer base frequency
// - symbol rate from mantissa and exponent
// - exponent low nibble reset 12, mantissa 34
`include "tpc_defs.svh"
`default_nettype none
module tpc_config_regs (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // serial register port
    input  wire logic                spi_csn,
    input  wire logic                spi_sclk,
    input  wire logic                spi_mosi,
    output var  logic                spi_miso,
    // data sources
    input  wire logic                fifo_bit,
    input  wire logic                general_output_0,
    input  wire logic [15:0]         chan_spacing,
    // packet handler configuration
    output var  logic [15:0]         sync_word,
    output var  logic [7:0]          packet_length,
    output var  logic [7:0]          station_id,
    output var  logic                whitening_enable,
    output var  logic                crc_enable,
    output var  tpc_pkg::tpc_fmt_type packet_source_format,
    output var  tpc_pkg::tpc_len_type length_mode,
    output var  logic                len_fixed,
    output var  logic                len_variable,
    output var  logic                len_infinite,
    // synthesizer
    output var  logic [7:0]          hop_index,
    output var  logic [23:0]         carrier_word,
    output var  logic [24:0]         op_freq,
    // modulator
    output var  logic [3:0]          rate_exponent,
    output var  logic [7:0]          rate_mantissa,
    output var  logic                symbol_tick,
    output var  logic                fifo_bit_take,
    output var  logic                tx_bit
);
    import tpc_pkg::*;

    // register storage
    logic [7:0]        sync_hi_r, sync_hi_nxt;
    logic [7:0]        sync_lo_r, sync_lo_nxt;
    logic [7:0]        pkt_len_r, pkt_len_nxt;
    logic [6:0]        ctrl_r, ctrl_nxt;
    logic [7:0]        station_r, station_nxt;
    logic [7:0]        hop_r, hop_nxt;
    logic [5:0]        car_hi_r, car_hi_nxt;
    logic [7:0]        car_mid_r, car_mid_nxt;
    logic [7:0]        car_lo_r, car_lo_nxt;
    logic [3:0]        rexp_r, rexp_nxt;
    logic [7:0]        rmant_r, rmant_nxt;

    // serial framing state
    tpc_spi_state_type st_r, st_nxt;
    logic [5:0]        addr_r, addr_nxt;
    logic              rd_r, rd_nxt;
    logic              burst_r, burst_nxt;
    logic [7:0]        rx_byte;
    logic              byte_done;
    logic [7:0]        tx_byte;
    logic              wr_en;

    // datapath state
    logic [`TPC_RATE_ACC_W-1:0] acc_r, acc_nxt;
    logic              tick_r, tick_nxt;
    logic [8:0]        pn9_r, pn9_nxt;
    logic              txb_r, txb_nxt;
    logic              take_r, take_nxt;
    logic [24:0]       freq_r, freq_nxt;
    logic [23:0]       rate_step;
    logic [`TPC_RATE_ACC_W:0] acc_sum;
    logic [23:0]       hop_prod;
    logic              lf_r, lf_nxt;
    logic              lv_r, lv_nxt;
    logic              li_r, li_nxt;

    // read value of one register address
    function automatic logic [7:0] reg_read(input logic [5:0] a);
        case (a)
            `TPC_OFS_SYNC_HI:     reg_read = sync_hi_r;
            `TPC_OFS_SYNC_LO:     reg_read = sync_lo_r;
            `TPC_OFS_PKT_LEN:     reg_read = pkt_len_r;
            `TPC_OFS_PKT_CTRL:    reg_read = {1'b0, ctrl_r};
            `TPC_OFS_STATION:     reg_read = station_r;
            `TPC_OFS_HOP:         reg_read = hop_r;
            `TPC_OFS_CARRIER_HI:  reg_read = {2'b00, car_hi_r};
            `TPC_OFS_CARRIER_MID: reg_read = car_mid_r;
            `TPC_OFS_CARRIER_LO:  reg_read = car_lo_r;
            `TPC_OFS_RATE_EXP:    reg_read = {`TPC_RATE_EXP_RSVD, rexp_r};
            `TPC_OFS_RATE_MANT:   reg_read = rmant_r;
            default:              reg_read = 8'h00;
        endcase
    endfunction

    // byte-level serial engine
    tpc_spi_shifter u_shift (
        .clk       (clk),
        .rst       (rst),
        .csn       (spi_csn),
        .sclk      (spi_sclk),
        .mosi      (spi_mosi),
        .miso      (spi_miso),
        .tx_byte   (tx_byte),
        .rx_byte   (rx_byte),
        .byte_done (byte_done)
    );

    // header byte, then data bytes; burst walks the address
    always_comb begin
        st_nxt    = st_r;
        addr_nxt  = addr_r;
        rd_nxt    = rd_r;
        burst_nxt = burst_r;
        tx_byte   = 8'h00;
        wr_en     = 1'b0;
        case (st_r)
            TPC_SPI_IDLE: begin
                if (!spi_csn) begin
                    st_nxt = TPC_SPI_ADDR;
                end
            end
            TPC_SPI_ADDR: begin
                if (byte_done) begin
                    addr_nxt  = rx_byte[5:0];
                    rd_nxt    = rx_byte[`TPC_HDR_READ_BIT];
                    burst_nxt = rx_byte[`TPC_HDR_BURST_BIT];
                    tx_byte   = reg_read(rx_byte[5:0]);
                    st_nxt    = TPC_SPI_DATA;
                end
            end
            TPC_SPI_DATA: begin
                if (byte_done) begin
                    wr_en = ~rd_r;
                    if (burst_r) begin
                        addr_nxt = addr_r + 6'h01;
                        tx_byte  = reg_read(addr_r + 6'h01);
                    end else begin
                        st_nxt = TPC_SPI_HOLD;
                    end
                end
            end
            TPC_SPI_HOLD: begin
                st_nxt = TPC_SPI_HOLD;
            end
            default: begin
                st_nxt = TPC_SPI_IDLE;
            end
        endcase
        if (spi_csn) begin
            st_nxt = TPC_SPI_IDLE;
        end
    end

    // register writes from the serial port
    always_comb begin
        sync_hi_nxt = sync_hi_r;
        sync_lo_nxt = sync_lo_r;
        pkt_len_nxt = pkt_len_r;
        ctrl_nxt    = ctrl_r;
        station_nxt = station_r;
        hop_nxt     = hop_r;
        car_hi_nxt  = car_hi_r;
        car_mid_nxt = car_mid_r;
        car_lo_nxt  = car_lo_r;
        rexp_nxt    = rexp_r;
        rmant_nxt   = rmant_r;
        if (wr_en) begin
            case (addr_r)
                `TPC_OFS_SYNC_HI:     sync_hi_nxt = rx_byte;
                `TPC_OFS_SYNC_LO:     sync_lo_nxt = rx_byte;
                `TPC_OFS_PKT_LEN:     pkt_len_nxt = rx_byte;
                `TPC_OFS_PKT_CTRL:    ctrl_nxt    = rx_byte[6:0];
                `TPC_OFS_STATION:     station_nxt = rx_byte;
                `TPC_OFS_HOP:         hop_nxt     = rx_byte;
                `TPC_OFS_CARRIER_HI:  car_hi_nxt  = rx_byte[5:0];
                `TPC_OFS_CARRIER_MID: car_mid_nxt = rx_byte;
                `TPC_OFS_CARRIER_LO:  car_lo_nxt  = rx_byte;
                `TPC_OFS_RATE_EXP:    rexp_nxt    = rx_byte[3:0];
                `TPC_OFS_RATE_MANT:   rmant_nxt   = rx_byte;
                default: begin
                    sync_hi_nxt = sync_hi_r;
                end
            endcase
        end
    end

    // register bank and framing flops
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_hi_r <= `TPC_RST_SYNC_HI;
            sync_lo_r <= `TPC_RST_SYNC_LO;
            pkt_len_r <= `TPC_RST_PKT_LEN;
            ctrl_r    <= `TPC_RST_PKT_CTRL;
            station_r <= `TPC_RST_STATION;
            hop_r     <= `TPC_RST_HOP;
            car_hi_r  <= `TPC_RST_CARRIER_HI;
            car_mid_r <= `TPC_RST_CARRIER_MID;
            car_lo_r  <= `TPC_RST_CARRIER_LO;
            rexp_r    <= `TPC_RST_RATE_EXP;
            rmant_r   <= `TPC_RST_RATE_MANT;
            st_r      <= TPC_SPI_IDLE;
            addr_r    <= 6'h00;
            rd_r      <= 1'b0;
            burst_r   <= 1'b0;
        end else begin
            sync_hi_r <= sync_hi_nxt;
            sync_lo_r <= sync_lo_nxt;
            pkt_len_r <= pkt_len_nxt;
            ctrl_r    <= ctrl_nxt;
            station_r <= station_nxt;
            hop_r     <= hop_nxt;
            car_hi_r  <= car_hi_nxt;
            car_mid_r <= car_mid_nxt;
            car_lo_r  <= car_lo_nxt;
            rexp_r    <= rexp_nxt;
            rmant_r   <= rmant_nxt;
            st_r      <= st_nxt;
            addr_r    <= addr_nxt;
            rd_r      <= rd_nxt;
            burst_r   <= burst_nxt;
        end
    end

    // symbol rate: hidden one on the mantissa, shifted by the exponent
    assign rate_step = 24'({1'b1, rmant_r}) << rexp_r;
    assign acc_sum   = {1'b0, acc_r} + {5'h00, rate_step};
    // channel offset added to the base word
    assign hop_prod  = hop_r * chan_spacing;

    // datapath next values
    always_comb begin
        acc_nxt  = acc_sum[`TPC_RATE_ACC_W-1:0];
        tick_nxt = acc_sum[`TPC_RATE_ACC_W];
        freq_nxt = {1'b0, 2'b00, car_hi_r, car_mid_r, car_lo_r} + {1'b0, hop_prod};
        pn9_nxt  = pn9_r;
        txb_nxt  = txb_r;
        take_nxt = 1'b0;
        case (tpc_fmt_type'(ctrl_r[`TPC_CTRL_FMT_LO +: 2]))
            TPC_FMT_FIFO: begin
                if (tick_r) begin
                    txb_nxt  = fifo_bit;
                    take_nxt = 1'b1;
                end
            end
            TPC_FMT_SYNC: begin
                if (tick_r) begin
                    txb_nxt = general_output_0;
                end
            end
            TPC_FMT_PN9: begin
                if (tick_r) begin
                    txb_nxt = pn9_r[0];
                    pn9_nxt = {pn9_r[0] ^ pn9_r[5], pn9_r[8:1]};
                end
            end
            TPC_FMT_ASYNC: begin
                txb_nxt = general_output_0;
            end
            default: begin
                txb_nxt = 1'b0;
            end
        endcase
        lf_nxt = 1'b0;
        lv_nxt = 1'b0;
        li_nxt = 1'b0;
        case (tpc_len_type'(ctrl_r[`TPC_CTRL_LEN_LO +: 2]))
            TPC_LEN_FIXED:    lf_nxt = 1'b1;
            TPC_LEN_VARIABLE: lv_nxt = 1'b1;
            TPC_LEN_INFINITE: li_nxt = 1'b1;
            default:          lf_nxt = 1'b0;
        endcase
    end

    // datapath flops
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_r  <= '0;
            tick_r <= 1'b0;
            pn9_r  <= `TPC_PN9_SEED;
            txb_r  <= 1'b0;
            take_r <= 1'b0;
            freq_r <= 25'h0;
            lf_r   <= 1'b0;
            lv_r   <= 1'b0;
            li_r   <= 1'b0;
        end else begin
            acc_r  <= acc_nxt;
            tick_r <= tick_nxt;
            pn9_r  <= pn9_nxt;
            txb_r  <= txb_nxt;
            take_r <= take_nxt;
            freq_r <= freq_nxt;
            lf_r   <= lf_nxt;
            lv_r   <= lv_nxt;
            li_r   <= li_nxt;
        end
    end

    // outputs, all taken from flops
    assign sync_word            = {sync_hi_r, sync_lo_r};
    assign packet_length        = pkt_len_r;
    assign station_id           = station_r;
    assign whitening_enable     = ctrl_r[`TPC_CTRL_WHITE_BIT];
    assign crc_enable           = ctrl_r[`TPC_CTRL_CRC_BIT];
    assign packet_source_format = tpc_fmt_type'(ctrl_r[`TPC_CTRL_FMT_LO +: 2]);
    assign length_mode          = tpc_len_type'(ctrl_r[`TPC_CTRL_LEN_LO +: 2]);
    assign len_fixed            = lf_r;
    assign len_variable         = lv_r;
    assign len_infinite         = li_r;
    assign hop_index            = hop_r;
    assign carrier_word         = {2'b00, car_hi_r, car_mid_r, car_lo_r};
    assign op_freq              = freq_r;
    assign rate_exponent        = rexp_r;
    assign rate_mantissa        = rmant_r;
    assign symbol_tick          = tick_r;
    assign fifo_bit_take        = take_r;
    assign tx_bit               = txb_r;
endmodule
`default_nettype wire

//--- tb/tpc_config_regs_chk.sv
`default_nettype none
module tpc_config_regs_chk (
    // clock and reset
    input wire logic                 clk,
    input wire logic                 rst,
    // inputs of the block
    input wire logic                 general_output_0,
    input wire logic [15:0]          chan_spacing,
    // configuration outputs
    input wire logic [15:0]          sync_word,
    input wire logic [7:0]           packet_length,
    input wire logic [7:0]           station_id,
    input wire logic                 whitening_enable,
    input wire logic                 crc_enable,
    input wire tpc_pkg::tpc_fmt_type packet_source_format,
    input wire tpc_pkg::tpc_len_type length_mode,
    input wire logic                 len_fixed,
    input wire logic                 len_variable,
    input wire logic                 len_infinite,
    input wire logic [7:0]           hop_index,
    input wire logic [23:0]          carrier_word,
    input wire logic [24:0]          op_freq,
    input wire logic [3:0]           rate_exponent,
    input wire logic [7:0]           rate_mantissa,
    input wire logic                 symbol_tick,
    input wire logic                 fifo_bit_take,
    input wire logic                 tx_bit
);
    import tpc_pkg::*;

    // all checks on the system clock, idle while reset is high
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sync_hi_rst_a: assert property ($fell(rst) |-> sync_word[15:8] == 8'hd3)
        else $error("sync high byte reset value wrong");
    sync_lo_rst_a: assert property ($fell(rst) |-> sync_word[7:0] == 8'h91)
        else $error("sync low byte reset value wrong");
    len_rst_a: assert property ($fell(rst) |-> packet_length == 8'hff)
        else $error("packet length reset value wrong");
    fifo_take_a: assert property (fifo_bit_take |-> $past(symbol_tick) && $past(packet_source_format) == TPC_FMT_FIFO)
        else $error("fifo bit taken outside fifo format or tick");
    sync_src_a: assert property ($past(symbol_tick) && $past(packet_source_format) == TPC_FMT_SYNC
        |-> tx_bit == $past(general_output_0))
        else $error("synchronous format bit not from pin");
    pn9_hold_a: assert property (packet_source_format == TPC_FMT_PN9 && $past(packet_source_format) == TPC_FMT_PN9
        && !$past(symbol_tick) && !$past(rst) |-> $stable(tx_bit))
        else $error("pattern bit moved without a tick");
    async_src_a: assert property ($past(packet_source_format) == TPC_FMT_ASYNC && !$past(rst)
        |-> tx_bit == $past(general_output_0))
        else $error("transparent format bit not from pin");
    len_fixed_a: assert property (!$past(rst) |-> len_fixed == ($past(length_mode) == TPC_LEN_FIXED))
        else $error("fixed length flag wrong");
    len_var_a: assert property (!$past(rst) |-> len_variable == ($past(length_mode) == TPC_LEN_VARIABLE))
        else $error("variable length flag wrong");
    len_inf_a: assert property (!$past(rst) |-> len_infinite == ($past(length_mode) == TPC_LEN_INFINITE))
        else $error("infinite length flag wrong");
    station_rst_a: assert property ($fell(rst) |-> station_id == 8'h00)
        else $error("station id reset value wrong");
    freq_sum_a: assert property (!$past(rst) |-> op_freq == 25'($past(carrier_word))
        + 25'($past(hop_index)) * 25'($past(chan_spacing)))
        else $error("operating frequency sum wrong");
    carrier_top_a: assert property (carrier_word[23:22] == 2'b00)
        else $error("carrier word top bits not zero");
    carrier_rst_a: assert property ($fell(rst) |-> carrier_word == 24'h1ec4ec)
        else $error("carrier word reset value wrong");
    rate_rst_a: assert property ($fell(rst) |-> rate_exponent == 4'hc && rate_mantissa == 8'h22)
        else $error("symbol rate reset value wrong");
    ctrl_rst_a: assert property ($fell(rst) |-> whitening_enable && crc_enable)
        else $error("whitening or crc reset value wrong");
endmodule

// attach to every instance of the register bank
bind tpc_config_regs tpc_config_regs_chk chk_u (
    .clk(clk), .rst(rst), .general_output_0(general_output_0), .chan_spacing(chan_spacing),
    .sync_word(sync_word), .packet_length(packet_length), .station_id(station_id),
    .whitening_enable(whitening_enable), .crc_enable(crc_enable), .packet_source_format(packet_source_format),
    .length_mode(length_mode), .len_fixed(len_fixed), .len_variable(len_variable), .len_infinite(len_infinite),
    .hop_index(hop_index), .carrier_word(carrier_word), .op_freq(op_freq), .rate_exponent(rate_exponent),
    .rate_mantissa(rate_mantissa), .symbol_tick(symbol_tick), .fifo_bit_take(fifo_bit_take), .tx_bit(tx_bit)
);
`default_nettype wire

//--- tb/tx_packet_config_registers_tb_top.sv
`default_nettype none
module tx_packet_config_registers_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import tpc_pkg::*;

    // stimulus
    logic        clk      = 1'b0;
    logic        rst      = 1'b1;
    logic        csn      = 1'b1;
    logic        sclk     = 1'b0;
    logic        mosi     = 1'b0;
    logic        fifo_bit = 1'b0;
    logic        g0       = 1'b0;
    logic [15:0] spacing  = 16'h1234;
    // observed outputs
    logic        miso, wen, crc, lf, lv, li, tick, take, txb;
    logic [15:0] sw, rdv;
    logic [7:0]  plen, sid, hop, mant;
    logic [3:0]  rexp;
    logic [23:0] cw;
    logic [24:0] opf;
    tpc_fmt_type fmt;
    tpc_len_type lm;
    int          fails    = 0;
    int          checked  = 0;
    // register table: offsets, reset reads, written values, readback
    logic [5:0]  adr [11] = '{6'h04, 6'h05, 6'h06, 6'h08, 6'h09, 6'h0a, 6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h11};
    logic [7:0]  rsv [11] = '{8'hd3, 8'h91, 8'hff, 8'h45, 8'h00, 8'h00, 8'h1e, 8'hc4, 8'hec, 8'h8c, 8'h22};
    logic [7:0]  wv  [11] = '{8'h5a, 8'ha5, 8'h3c, 8'hff, 8'h7e, 8'h81, 8'hff, 8'h12, 8'h34, 8'hf5, 8'hc3};
    logic [7:0]  rbv [11] = '{8'h5a, 8'ha5, 8'h3c, 8'h7f, 8'h7e, 8'h81, 8'h3f, 8'h12, 8'h34, 8'h85, 8'hc3};

`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fails++; $display("[FAIL] %s exp %h got %h", n, e, g); end end

    // system clock
    always #5 clk = ~clk;

    tpc_config_regs dut_u (
        .clk(clk), .rst(rst), .spi_csn(csn), .spi_sclk(sclk), .spi_mosi(mosi), .spi_miso(miso),
        .fifo_bit(fifo_bit), .general_output_0(g0), .chan_spacing(spacing), .sync_word(sw),
        .packet_length(plen), .station_id(sid), .whitening_enable(wen), .crc_enable(crc),
        .packet_source_format(fmt), .length_mode(lm), .len_fixed(lf), .len_variable(lv), .len_infinite(li),
        .hop_index(hop), .carrier_word(cw), .op_freq(opf), .rate_exponent(rexp), .rate_mantissa(mant),
        .symbol_tick(tick), .fifo_bit_take(take), .tx_bit(txb)
    );

    // verdict and end of run
    task automatic conclude();
        if (fails == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // wait n edges, then step just past the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // one frame of n bytes with the header, mode 0, three clocks per serial half period
    task automatic spi(input logic [7:0] h, input logic [15:0] d, input int n, output logic [15:0] r);
        logic [23:0] s;
        s = {h, d};
        r = 16'h0000;
        csn = 1'b0;
        cyc(3);
        for (int i = 23; i >= 24 - 8 * n; i--) begin
            mosi = s[i];
            cyc(3);
            if (i < 16) r[i] = miso;
            sclk = 1'b1;
            cyc(3);
            sclk = 1'b0;
        end
        cyc(4);
        csn = 1'b1;
        cyc(4);
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        spi({2'b00, a}, {d, 8'h00}, 2, rdv);
    endtask

    task automatic rd(input logic [5:0] a, output logic [7:0] r);
        logic [15:0] w;
        spi({2'b10, a}, 16'h0000, 2, w);
        r = w[15:8];
    endtask

    // burst write then burst read across both sync bytes
    task automatic t_burst();
        logic [15:0] w;
        spi({2'b01, 6'h04}, 16'h1357, 3, w);
        `CHK("burst write", 16'h1357, sw)
        spi({2'b11, 6'h04}, 16'h0000, 3, w);
        `CHK("burst read", 16'h1357, w)
    endtask

    // reset values through the port and at the outputs
    task automatic t_reset();
        logic [7:0] r;
        for (int i = 0; i < 11; i++) begin
            rd(adr[i], r);
            `CHK("reset read", rsv[i], r)
        end
        `CHK("sync word", 16'hd391, sw)
        `CHK("carrier word", 24'h1ec4ec, cw)
        `CHK("variable flag", 1'b1, lv)
    endtask

    // write every register, read back, unmapped place, outputs
    task automatic t_write();
        logic [7:0] r;
        for (int i = 0; i < 11; i++) wr(adr[i], wv[i]);
        wr(6'h07, 8'h77);
        for (int i = 0; i < 11; i++) begin
            rd(adr[i], r);
            `CHK("readback", rbv[i], r)
        end
        rd(6'h07, r);
        `CHK("unmapped read", 8'h00, r)
        `CHK("sync word", 16'h5aa5, sw)
        `CHK("length", 8'h3c, plen)
        `CHK("station", 8'h7e, sid)
        `CHK("hop", 8'h81, hop)
        `CHK("carrier word", 24'h3f1234, cw)
        `CHK("op freq", 25'h3f1234 + 25'h81 * 25'h1234, opf)
        `CHK("rate fields", 12'h5c3, {rexp, mant})
        `CHK("ctrl on", 4'hf, {wen, crc, fmt})
        wr(6'h08, 8'h00);
        `CHK("ctrl off", 4'h0, {wen, crc, fmt})
    endtask

    // every length configuration and its flags
    task automatic t_len();
        for (int m = 0; m < 4; m++) begin
            wr(6'h08, 8'(m));
            `CHK("length mode", 2'(m), lm)
            `CHK("length flags", {m == 0, m == 1, m == 2}, {lf, lv, li})
        end
    endtask

    // every data source at a fast symbol rate
    task automatic t_fmt();
        int     tk;
        int     tkn;
        int     ones;
        logic   hi;
        logic   lo;
        longint e;
        e = (64'd1000 * (64'd290 << 15)) >> 28;
        wr(6'h10, 8'h0f);
        wr(6'h11, 8'h22);
        for (int f = 0; f < 4; f++) begin
            wr(6'h08, {2'b00, 2'(f), 4'h0});
            tk = 0;
            tkn = 0;
            ones = 0;
            for (int i = 0; i < 1000; i++) begin
                g0 = (i < 500);
                fifo_bit = i[1];
                cyc(1);
                tk += int'(tick);
                tkn += int'(take);
                ones += int'(txb);
                if (i == 498) hi = txb;
            end
            lo = txb;
            `CHK("format", 2'(f), fmt)
            `CHK("tick count", 1'b1, tk >= e && tk <= e + 1)
            `CHK("fifo takes", f == 0, tkn > 0)
            if (f == 1 || f == 3) begin
                `CHK("pin high", 1'b1, hi)
                `CHK("pin low", 1'b0, lo)
            end
            if (f == 2) `CHK("pattern mix", 1'b1, ones > 50 && ones < 950)
        end
    endtask

    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        cyc(2);
        t_reset();
        t_write();
        t_burst();
        t_len();
        t_fmt();
        conclude();
    end

    // hang guard
    initial begin
        #300000;
        fails++;
        conclude();
    end
endmodule
`default_nettype wire
